// ---- logic/tss_slot_source_selector.sv ----
// What this block does
// - entry address is prefix, highway, slot, byte
// - slots beyond highway slot count never consulted
// - entry memory never cleared by any reset
// - source slot from first byte low seven bits
// - second byte upper three bits pick source
// - receive highway field used only stored modes
// - low-latency takes most recent stored copy
// - frame-integrity takes only completed receive frames
// - host byte sent every frame
// - host-byte mode ignores receive highway field
// - idle modes send matching idle register value
// - test-pattern mode sends selected pattern style
// - high-impedance mode releases that single slot
// - first byte meaningless for modes three-seven
// - external driver option drives high-impedance slots
// - receive writes store; host writes ignored
//
// The address map and the address-and-strobe port were chosen for this implementation.
`default_nettype none
module tss_slot_source_selector
    import tss_pkg::*;
#(
    parameter int NUM_HWY = 32,
    parameter int NUM_SLOT = 128
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] hostAddr,
    input wire logic [BYTE_W-1:0] hostWrData,
    input wire logic hostWrStb,
    input wire logic hostRdStb,
    output logic [BYTE_W-1:0] hostRdData,
    input wire logic rxWrite,
    input wire logic [HWY_W-1:0] rxHighway,
    input wire logic [SLOT_W-1:0] rxSlot,
    input wire logic [BYTE_W-1:0] rxByte,
    input wire logic rxFrameEnd,
    input wire logic txReq,
    input wire logic [HWY_W-1:0] txHighway,
    input wire logic [SLOT_W-1:0] txSlot,
    input wire logic [SLOT_W:0] txSlotCount,
    output logic txValid,
    output logic [BYTE_W-1:0] txByte,
    output logic transmitDriveIndicator
);
    // memories carry no reset on purpose: contents survive every reset
    logic [BYTE_W-1:0] slotSourceOrHostByte [0:NUM_HWY*NUM_SLOT-1];
    logic [BYTE_W-1:0] slotModeAndHighway [0:NUM_HWY*NUM_SLOT-1];
    logic [BYTE_W-1:0] dataStore [0:2*NUM_HWY*NUM_SLOT-1];

    logic [1:0] ctrl_reg, ctrl_next;
    logic [BYTE_W-1:0] idle1_reg, idle1_next, idle2_reg, idle2_next, idle3_reg, idle3_next;
    logic [BYTE_W-1:0] testByte_reg, testByte_next;
    logic [14:0] prbs_reg, prbs_next;
    logic [BYTE_W-1:0] rdData_reg, rdData_next;
    logic [NUM_HWY-1:0] rxBank_reg, rxBank_next;
    logic [SLOT_W-1:0] rxPos_reg [0:NUM_HWY-1];
    logic [SLOT_W-1:0] rxPos_next [0:NUM_HWY-1];

    logic s1Valid_reg, s1Valid_next, s1Skip_reg, s1Skip_next, s1Bank_reg, s1Bank_next;
    tss_mode_type s1Mode_reg, s1Mode_next;
    logic [HWY_W-1:0] s1RxHwy_reg, s1RxHwy_next;
    logic [SLOT_W-1:0] s1RxSlot_reg, s1RxSlot_next;
    logic [BYTE_W-1:0] s1Byte0_reg, s1Byte0_next;
    logic txValid_reg, txValid_next, txDrive_reg, txDrive_next;
    logic [BYTE_W-1:0] txByte_reg, txByte_next;

    logic [1:0] space;
    logic [CS_IDX_W-1:0] hostCsIdx, txCsIdx;
    logic [DS_IDX_W-1:0] rxDsIdx, hostDsIdx, txDsIdx;
    logic csWrite, extDrv, prbsStyle, bankBefore;
    logic [BYTE_W-1:0] entryByte1;
    logic [HWY_W-1:0] entryRxHwy;

    assign space = hostAddr[SPACE_HI:SPACE_LO];
    assign hostCsIdx = hostAddr[CS_IDX_W:1];
    assign txCsIdx = {txHighway, txSlot};
    assign rxDsIdx = {rxBank_reg[rxHighway], rxHighway, rxSlot};
    // host sees the last completed frame of the receive highway
    assign hostDsIdx = {~rxBank_reg[hostAddr[CS_IDX_W-1:SLOT_W]], hostAddr[CS_IDX_W-1:0]};
    assign txDsIdx = {s1Bank_reg, s1RxHwy_reg, s1RxSlot_reg};
    assign csWrite = hostWrStb && (space == SPACE_CS);
    assign extDrv = ctrl_reg[CTRL_EXT_DRIVER_BIT];
    assign prbsStyle = ctrl_reg[CTRL_PRBS_STYLE_BIT];
    assign bankBefore = rxBank_reg[rxHighway];
    assign entryByte1 = slotModeAndHighway[txCsIdx];
    assign entryRxHwy = entryByte1[RXHWY_HI:RXHWY_LO];

    // host-written entry memory and receive-written data store, no reset branch
    always_ff @(posedge ref_clk) begin
        if (csWrite && hostAddr[CS_BYTE_SEL]) begin
            slotModeAndHighway[hostCsIdx] <= hostWrData;
        end
        if (csWrite && !hostAddr[CS_BYTE_SEL]) begin
            slotSourceOrHostByte[hostCsIdx] <= hostWrData;
        end
        if (rxWrite) begin
            dataStore[rxDsIdx] <= rxByte;
        end
    end

    // host register file
    always_comb begin
        ctrl_next = ctrl_reg;
        idle1_next = idle1_reg;
        idle2_next = idle2_reg;
        idle3_next = idle3_reg;
        testByte_next = testByte_reg;
        rdData_next = BYTE_RESET;
        if (hostWrStb && space == SPACE_CFG) begin
            if (hostAddr == CFG_CTRL) begin
                ctrl_next = hostWrData[1:0];
            end else if (hostAddr == CFG_IDLE1) begin
                idle1_next = hostWrData;
            end else if (hostAddr == CFG_IDLE2) begin
                idle2_next = hostWrData;
            end else if (hostAddr == CFG_IDLE3) begin
                idle3_next = hostWrData;
            end else if (hostAddr == CFG_TEST_BYTE) begin
                testByte_next = hostWrData;
            end
        end
        // writes into the data store space fall through untouched
        if (hostRdStb) begin
            if (space == SPACE_CS && hostAddr[CS_BYTE_SEL]) begin
                rdData_next = slotModeAndHighway[hostCsIdx];
            end else if (space == SPACE_CS) begin
                rdData_next = slotSourceOrHostByte[hostCsIdx];
            end else if (space == SPACE_DS) begin
                rdData_next = dataStore[hostDsIdx];
            end else if (hostAddr == CFG_CTRL) begin
                rdData_next = {6'h00, ctrl_reg};
            end else if (hostAddr == CFG_IDLE1) begin
                rdData_next = idle1_reg;
            end else if (hostAddr == CFG_IDLE2) begin
                rdData_next = idle2_reg;
            end else if (hostAddr == CFG_IDLE3) begin
                rdData_next = idle3_reg;
            end else if (hostAddr == CFG_TEST_BYTE) begin
                rdData_next = testByte_reg;
            end else if (hostAddr == CFG_PATTERN_STATE) begin
                rdData_next = prbs_reg[BYTE_W-1:0];
            end
        end
    end

    // receive bank and fill position per highway
    always_comb begin
        rxBank_next = rxBank_reg;
        for (int h = 0; h < NUM_HWY; h++) begin
            rxPos_next[h] = rxPos_reg[h];
        end
        if (rxWrite) begin
            rxPos_next[rxHighway] = rxSlot + 7'h01;
        end
        if (rxFrameEnd) begin
            rxBank_next[rxHighway] = ~rxBank_reg[rxHighway];
            rxPos_next[rxHighway] = 7'h00;
        end
    end

    // stage 1: entry fetch, one slot time ahead of the output
    always_comb begin
        s1Valid_next = txReq;
        s1Skip_next = ({1'b0, txSlot} >= txSlotCount);
        s1Mode_next = tss_mode_type'(entryByte1[MODE_HI:MODE_LO]);
        s1RxHwy_next = entryRxHwy;
        s1Byte0_next = slotSourceOrHostByte[txCsIdx];
        s1RxSlot_next = s1Byte0_next[SLOT_W-1:0];
        // most recent copy: this frame's bank once the slot has landed
        if (s1Mode_next == MODE_LOW_LATENCY) begin
            s1Bank_next = (s1RxSlot_next < rxPos_reg[entryRxHwy])
                ? rxBank_reg[entryRxHwy] : ~rxBank_reg[entryRxHwy];
        end else begin
            s1Bank_next = ~rxBank_reg[entryRxHwy];
        end
    end

    // stage 2: source choice
    always_comb begin
        prbs_next = prbs_reg;
        txValid_next = s1Valid_reg;
        txDrive_next = 1'b0;
        txByte_next = BYTE_RESET;
        if (s1Valid_reg && !s1Skip_reg) begin
            txDrive_next = 1'b1;
            case (s1Mode_reg)
                MODE_LOW_LATENCY, MODE_FRAME_INTEGRITY: begin
                    txByte_next = dataStore[txDsIdx];
                end
                MODE_HOST_BYTE: begin
                    txByte_next = s1Byte0_reg;
                end
                MODE_IDLE1: begin
                    txByte_next = idle1_reg;
                end
                MODE_IDLE2: begin
                    txByte_next = idle2_reg;
                end
                MODE_IDLE3: begin
                    txByte_next = idle3_reg;
                end
                MODE_TEST_PATTERN: begin
                    txByte_next = prbsStyle ? prbs_reg[BYTE_W-1:0] : testByte_reg;
                    prbs_next = {prbs_reg[13:0], prbs_reg[14] ^ prbs_reg[13]};
                end
                default: begin
                    // filler is the pattern state: arbitrary but harmless
                    txDrive_next = extDrv;
                    txByte_next = prbs_reg[BYTE_W-1:0];
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= CTRL_RESET;
            idle1_reg <= BYTE_RESET;
            idle2_reg <= BYTE_RESET;
            idle3_reg <= BYTE_RESET;
            testByte_reg <= BYTE_RESET;
            rdData_reg <= BYTE_RESET;
            prbs_reg <= PRBS_SEED;
            rxBank_reg <= '0;
            for (int h = 0; h < NUM_HWY; h++) begin
                rxPos_reg[h] <= '0;
            end
            s1Valid_reg <= 1'b0;
            s1Skip_reg <= 1'b0;
            s1Bank_reg <= 1'b0;
            s1Mode_reg <= MODE_HIGH_Z;
            s1RxHwy_reg <= '0;
            s1RxSlot_reg <= '0;
            s1Byte0_reg <= BYTE_RESET;
            txValid_reg <= 1'b0;
            txDrive_reg <= 1'b0;
            txByte_reg <= BYTE_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
            idle1_reg <= idle1_next;
            idle2_reg <= idle2_next;
            idle3_reg <= idle3_next;
            testByte_reg <= testByte_next;
            rdData_reg <= rdData_next;
            prbs_reg <= prbs_next;
            rxBank_reg <= rxBank_next;
            for (int h = 0; h < NUM_HWY; h++) begin
                rxPos_reg[h] <= rxPos_next[h];
            end
            s1Valid_reg <= s1Valid_next;
            s1Skip_reg <= s1Skip_next;
            s1Bank_reg <= s1Bank_next;
            s1Mode_reg <= s1Mode_next;
            s1RxHwy_reg <= s1RxHwy_next;
            s1RxSlot_reg <= s1RxSlot_next;
            s1Byte0_reg <= s1Byte0_next;
            txValid_reg <= txValid_next;
            txDrive_reg <= txDrive_next;
            txByte_reg <= txByte_next;
        end
    end

    assign hostRdData = rdData_reg;
    assign txValid = txValid_reg;
    assign txByte = txByte_reg;
    assign transmitDriveIndicator = txDrive_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence sLive;
        s1Valid_reg && !s1Skip_reg;
    endsequence

    a_tx_latency: assert property (txReq |-> ##2 txValid)
        else $error("slot byte not ready two cycles after request");
    a_tx_quiet: assert property (!txReq |-> ##2 !txValid)
        else $error("slot answer without a request");
    a_beyond_count: assert property (
        txReq && ({1'b0, txSlot} >= txSlotCount) |-> ##2 (txValid && !transmitDriveIndicator))
        else $error("slot beyond highway count was driven");
    a_hiz_release: assert property (
        sLive ##0 (s1Mode_reg == MODE_HIGH_Z) |=> transmitDriveIndicator == $past(extDrv))
        else $error("high impedance slot drive wrong");
    a_idle_two: assert property (
        sLive ##0 (s1Mode_reg == MODE_IDLE2) |=> txDrive_reg && txByte == $past(idle2_reg))
        else $error("idle code 2 not sent");
    a_host_byte: assert property (
        sLive ##0 (s1Mode_reg == MODE_HOST_BYTE) |=> txByte == $past(s1Byte0_reg))
        else $error("host byte not sent");
    a_frame_bank: assert property (
        rxFrameEnd |=> rxBank_reg[$past(rxHighway)] != $past(bankBefore))
        else $error("receive bank did not swap at frame end");
    a_entry_write: assert property (
        csWrite && hostAddr[CS_BYTE_SEL] |=> slotModeAndHighway[$past(hostCsIdx)]
            == $past(hostWrData))
        else $error("second entry byte not stored");
    a_rx_store: assert property (rxWrite |=> dataStore[$past(rxDsIdx)] == $past(rxByte))
        else $error("receive byte not stored");
    a_read_idle: assert property (
        hostRdStb && hostAddr == CFG_IDLE1 |=> hostRdData == $past(idle1_reg))
        else $error("idle code 1 read back wrong");
endmodule // tss_slot_source_selector
`default_nettype wire

// ---- logic/tss_pkg.sv ----
`default_nettype none
package tss_pkg;
    localparam int ADDR_W = 15;
    localparam int HWY_W = 5;
    localparam int SLOT_W = 7;
    localparam int BYTE_W = 8;
    localparam int MODE_W = 3;
    localparam int CS_IDX_W = HWY_W + SLOT_W;
    localparam int DS_IDX_W = CS_IDX_W + 1;

    // top address bits pick the space
    localparam logic [1:0] SPACE_CFG = 2'h0;
    localparam logic [1:0] SPACE_DS = 2'h1;
    localparam logic [1:0] SPACE_CS = 2'h2;
    localparam int SPACE_HI = 14;
    localparam int SPACE_LO = 13;
    localparam int CS_BYTE_SEL = 0;

    // configuration space offsets
    localparam logic [ADDR_W-1:0] CFG_CTRL = 15'h0000;
    localparam logic [ADDR_W-1:0] CFG_IDLE1 = 15'h0001;
    localparam logic [ADDR_W-1:0] CFG_IDLE2 = 15'h0002;
    localparam logic [ADDR_W-1:0] CFG_IDLE3 = 15'h0003;
    localparam logic [ADDR_W-1:0] CFG_TEST_BYTE = 15'h0004;
    localparam logic [ADDR_W-1:0] CFG_PATTERN_STATE = 15'h0005;

    // control register fields
    localparam int CTRL_EXT_DRIVER_BIT = 0;
    localparam int CTRL_PRBS_STYLE_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;

    // second entry byte layout
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 5;
    localparam int RXHWY_HI = 4;
    localparam int RXHWY_LO = 0;

    typedef enum logic [MODE_W-1:0] {
        MODE_LOW_LATENCY = 3'h0,
        MODE_FRAME_INTEGRITY = 3'h1,
        MODE_HOST_BYTE = 3'h2,
        MODE_IDLE1 = 3'h3,
        MODE_IDLE2 = 3'h4,
        MODE_IDLE3 = 3'h5,
        MODE_TEST_PATTERN = 3'h6,
        MODE_HIGH_Z = 3'h7
    } tss_mode_type;

    localparam logic [14:0] PRBS_SEED = 15'h7FFF;
endpackage
`default_nettype wire

// ---- testbench/tss_rx_feeder.sv ----
`default_nettype none
module tss_rx_feeder
    import tss_pkg::*;
(
    input wire logic ref_clk,
    output logic rxWrite,
    output logic [HWY_W-1:0] rxHighway,
    output logic [SLOT_W-1:0] rxSlot,
    output logic [BYTE_W-1:0] rxByte,
    output logic rxFrameEnd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {rxWrite, rxHighway, rxSlot, rxByte, rxFrameEnd} = '0;
    end
    // one frame on a receive highway, byte of slot s is base+s
    task automatic send(input logic [HWY_W-1:0] hwy, input logic [BYTE_W-1:0] base,
                        input int n, input logic last);
        for (int s = 0; s < n; s++) begin
            @(posedge ref_clk);
            rxWrite <= 1'b1;
            {rxHighway, rxSlot} <= {hwy, SLOT_W'(s)};
            rxByte <= base + BYTE_W'(s);
            rxFrameEnd <= last && (s == n - 1);
        end
        @(posedge ref_clk);
        {rxWrite, rxFrameEnd} <= 2'h0;
        // stale byte flips so a late sample cannot look right
        rxByte <= ~rxByte;
    endtask
endmodule // tss_rx_feeder
`default_nettype wire

// ---- testbench/testbench.sv ----
`default_nettype none
module testbench
    import tss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, resetn, hostWrStb, hostRdStb, txReq, txValid, transmitDriveIndicator;
    logic [ADDR_W-1:0] hostAddr;
    logic [BYTE_W-1:0] hostWrData, hostRdData, txByte, rxByte;
    logic rxWrite, rxFrameEnd;
    logic [HWY_W-1:0] rxHighway, txHighway;
    logic [SLOT_W-1:0] rxSlot, txSlot;
    logic [SLOT_W:0] txSlotCount;
    int mismatches = 0;
    int num_checks = 0;

    tss_slot_source_selector u_tss_slot_source_selector (.ref_clk(ref_clk), .resetn(resetn),
        .hostAddr(hostAddr), .hostWrData(hostWrData), .hostWrStb(hostWrStb),
        .hostRdStb(hostRdStb), .hostRdData(hostRdData), .rxWrite(rxWrite),
        .rxHighway(rxHighway), .rxSlot(rxSlot), .rxByte(rxByte), .rxFrameEnd(rxFrameEnd),
        .txReq(txReq), .txHighway(txHighway), .txSlot(txSlot), .txSlotCount(txSlotCount),
        .txValid(txValid), .txByte(txByte), .transmitDriveIndicator(transmitDriveIndicator));
    tss_rx_feeder u_tss_rx_feeder (.ref_clk(ref_clk), .rxWrite(rxWrite),
        .rxHighway(rxHighway), .rxSlot(rxSlot), .rxByte(rxByte), .rxFrameEnd(rxFrameEnd));

    always #50 ref_clk = ~ref_clk;

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [ADDR_W-1:0] ea(input logic [4:0] h, input logic [6:0] s,
                                             input logic b);
        return {SPACE_CS, h, s, b};
    endfunction
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        {hostWrStb, hostAddr, hostWrData} <= {1'b1, a, d};
        @(posedge ref_clk);
        hostWrStb <= 1'b0;
    endtask
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        {hostRdStb, hostAddr} <= {1'b1, a};
        @(posedge ref_clk);
        hostRdStb <= 1'b0;
        #1 check("hostRdData", exp, hostRdData);
    endtask
    task automatic ent(input logic [4:0] h, input logic [6:0] s, input logic [7:0] b0,
                       input logic [7:0] b1);
        wr(ea(h, s, 1'b0), b0);
        wr(ea(h, s, 1'b1), b1);
    endtask
    // answer lands exactly one cycle after the request is taken
    task automatic tx(input logic [4:0] h, input logic [6:0] s, input logic [7:0] n,
                      input logic [7:0] b, input logic d, input bit cb);
        @(posedge ref_clk);
        {txReq, txHighway, txSlot, txSlotCount} <= {1'b1, h, s, n};
        @(posedge ref_clk);
        txReq <= 1'b0;
        #1 check("txValid early", 8'h00, {7'h0, txValid});
        @(posedge ref_clk);
        #1 check("txValid", 8'h01, {7'h0, txValid});
        check("drive", {7'h0, d}, {7'h0, transmitDriveIndicator});
        if (cb) check("txByte", b, txByte);
    endtask

    task automatic t_host();
        ent(5'd6, 7'd7, 8'hA5, {MODE_HOST_BYTE, 5'h1F});
        rdc(15'h460E, 8'hA5);
        rdc(15'h460F, {MODE_HOST_BYTE, 5'h1F});
        tx(5'd6, 7'd7, 8'd128, 8'hA5, 1'b1, 1'b1);
        $display("test host byte done");
    endtask
    task automatic t_idle();
        for (int m = 0; m < 3; m++) begin
            wr(15'(CFG_IDLE1 + m), 8'(8'h31 + m));
            ent(5'd1, 7'(m), 8'hFF, {3'(m + 3), 5'h1F});
            tx(5'd1, 7'(m), 8'd128, 8'(8'h31 + m), 1'b1, 1'b1);
        end
        $display("test idle codes done");
    endtask
    task automatic t_test_hiz();
        wr(CFG_CTRL, 8'h00);
        wr(CFG_TEST_BYTE, 8'h5C);
        ent(5'd2, 7'd0, 8'hFF, {MODE_TEST_PATTERN, 5'h1F});
        tx(5'd2, 7'd0, 8'd128, 8'h5C, 1'b1, 1'b1);
        ent(5'd2, 7'd1, 8'hFF, {MODE_HIGH_Z, 5'h1F});
        tx(5'd2, 7'd1, 8'd128, 8'h00, 1'b0, 1'b0);
        wr(CFG_CTRL, 8'h01);
        tx(5'd2, 7'd1, 8'd128, 8'h00, 1'b1, 1'b0);
        tx(5'd2, 7'd0, 8'd128, 8'h5C, 1'b1, 1'b1);
        // two test slots so far: seed 7FFF stepped twice gives 7FFC
        wr(CFG_CTRL, 8'h02);
        rdc(CFG_CTRL, 8'h02);
        rdc(CFG_PATTERN_STATE, 8'hFC);
        tx(5'd2, 7'd0, 8'd128, 8'hFC, 1'b1, 1'b1);
        wr(CFG_CTRL, 8'h00);
        $display("test pattern and release done");
    endtask
    task automatic t_limit();
        ent(5'd2, 7'd32, 8'h77, {MODE_HOST_BYTE, 5'h00});
        tx(5'd2, 7'd32, 8'd64, 8'h77, 1'b1, 1'b1);
        tx(5'd2, 7'd32, 8'd32, 8'h00, 1'b0, 1'b1);
        $display("test slot limit done");
    endtask
    task automatic t_store();
        u_tss_rx_feeder.send(5'd3, 8'h10, 8, 1'b1);
        u_tss_rx_feeder.send(5'd3, 8'h20, 8, 1'b0);
        ent(5'd6, 7'd7, 8'h04, {MODE_FRAME_INTEGRITY, 5'd3});
        tx(5'd6, 7'd7, 8'd128, 8'h14, 1'b1, 1'b1);
        ent(5'd6, 7'd7, 8'h84, {MODE_LOW_LATENCY, 5'd3});
        tx(5'd6, 7'd7, 8'd128, 8'h24, 1'b1, 1'b1);
        // receive highway 3, slot 4 in the data store space
        rdc(15'h2184, 8'h14);
        wr(15'h2184, 8'hEE);
        rdc(15'h2184, 8'h14);
        $display("test stored sources done");
    endtask
    task automatic t_reset();
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check("txValid in reset", 8'h00, {7'h0, txValid});
        check("hostRdData in reset", 8'h00, hostRdData);
        resetn <= 1'b1;
        rdc(ea(5'd6, 7'd7, 1'b0), 8'h84);
        tx(5'd2, 7'd32, 8'd128, 8'h77, 1'b1, 1'b1);
        $display("test reset keeps entries done");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        resetn = 1'b0;
        {hostAddr, hostWrData, hostWrStb, hostRdStb} = '0;
        {txReq, txHighway, txSlot, txSlotCount} = '0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        t_host();
        t_idle();
        t_test_hiz();
        t_limit();
        t_store();
        t_reset();
        summarize();
    end
    // run needs well under a thousand cycles
    initial begin
        #300000;
        mismatches++;
        summarize();
    end
endmodule // testbench
`default_nettype wire
